// ==== hdl/surge_defines.vh ====
// constants for the cold-load surge detector
`ifndef SURGE_DEFINES_VH
`define SURGE_DEFINES_VH

// ----------------------------------------
// thresholds, units of 0.01 x nominal
// ----------------------------------------
`define THR_LOW_RST      16'h0014
`define THR_HIGH_RST     16'h0078
`define THR_OVER_RST     16'h00c8
`define HYST_NUM         7'h61
`define HYST_DEN         7'h64

// ----------------------------------------
// timers, units of ms, 5 ms tick
// ----------------------------------------
`define TICK_MS          24'h000005
`define CLOCK_MHZ        100
`define TICK_CYCLES      (`TICK_MS * 1000 * `CLOCK_MHZ)
`define T_START_MS       10000
`define T_MAX_MS         30000
`define T_MIN_MS         40

// ----------------------------------------
// condition status codes
// ----------------------------------------
`define COND_NORMAL      3'h0
`define COND_LOW         3'h1
`define COND_OVER        3'h2
`define COND_ACTIVE      3'h3
`define COND_BLOCKED     3'h4

// ----------------------------------------
// node mode codes
// ----------------------------------------
`define MODE_ON          3'h0
`define MODE_BLOCKED     3'h1
`define MODE_TEST        3'h2
`define MODE_TEST_BLK    3'h3
`define MODE_OFF         3'h4
`define MODE_HIDDEN      3'h7

`endif

// ==== hdl/cold_load_detector.v ====
// cold-load surge detector: thresholds, timers, blocking, status
// Function
// - three phase magnitudes, 5 ms refresh
// - one shared threshold per type
// - clear only past 97 percent
// - low default 0.20, all phases below
// - high default 1.20, all phases above
// - over default 2.00, any phase releases
// - all-phase low count triggers pick-up
// - thresholds may change while running
// - block sampled at cycle start
// - unblocked pick-up asserts activation, timers run
// - blocked pick-up asserts blocked, no timing
// - block during activation runs release
// - five-state condition status readout
// - node mode shown when enabled
// - start timer before activation, zero immediate
// - maximum timer above high releases
// - minimum hold and reclaim time
`include "surge_defines.vh"

module cold_load_detector
#(
	parameter MAG_W       = 16,
	parameter TIME_W      = 24,
	parameter TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire              clock,
	input  wire              arst_n,
	input  wire              clk_en,
	input  wire [MAG_W-1:0]  phase_a_magnitude,
	input  wire [MAG_W-1:0]  phase_b_magnitude,
	input  wire [MAG_W-1:0]  phase_c_magnitude,
	input  wire [MAG_W-1:0]  thr_low,
	input  wire [MAG_W-1:0]  thr_high,
	input  wire [MAG_W-1:0]  thr_over,
	input  wire [TIME_W-1:0] t_start_ms,
	input  wire [TIME_W-1:0] t_max_ms,
	input  wire [TIME_W-1:0] t_min_ms,
	input  wire              block_in,
	input  wire              node_test,
	input  wire              node_off,
	input  wire              node_mode_enable,
	output reg               surge_active_out,
	output reg               surge_blocked_out,
	output reg               tick_out,
	output reg  [2:0]        surge_condition_status,
	output reg  [2:0]        node_mode_status
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ACT  = 2'h1;
	localparam ST_BLK  = 2'h2;
	localparam TW = 32;

	// ----------------------------------------
	// processing tick
	// ----------------------------------------
	reg [TW-1:0] tick_cnt_q;
	wire         tick = (tick_cnt_q == TICK_CYCLES - 1);

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_q <= {TW{1'b0}};
		else if (clk_en)
			tick_cnt_q <= tick ? {TW{1'b0}} : tick_cnt_q + 1'b1;
	end

	// ----------------------------------------
	// block input synchroniser
	// ----------------------------------------
	reg [2:0] blk_sync_q;
	reg       blk_stable_q;
	reg       blk_sampled_q;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			blk_sync_q   <= 3'h0;
			blk_stable_q <= 1'b0;
		end
		else if (clk_en)
		begin
			blk_sync_q <= {blk_sync_q[1:0], block_in};
			if (blk_sync_q[1] == blk_sync_q[2])
				blk_stable_q <= blk_sync_q[2];
		end
	end

	// ----------------------------------------
	// threshold comparison with hysteresis
	// ----------------------------------------
	// magnitudes captured once per tick
	reg  [MAG_W-1:0] mag_q [0:2];
	reg  [2:0]       over_q, high_q, low_q;
	wire [MAG_W+7:0] thr_l97 = thr_low  * `HYST_NUM;
	wire [MAG_W+7:0] thr_h97 = thr_high * `HYST_NUM;
	wire [MAG_W+7:0] thr_o97 = thr_over * `HYST_NUM;
	reg  [2:0]       over_d, high_d, low_d;
	reg  [MAG_W+7:0] m100;
	integer          i;

	always @*
	begin
		m100 = {(MAG_W+8){1'b0}};
		for (i = 0; i < 3; i = i + 1)
		begin
			m100 = mag_q[i] * `HYST_DEN;
			// over: set above, clear below 97 percent
			over_d[i] = over_q[i] ? (m100 > thr_o97)
				: (mag_q[i] > thr_over);
			high_d[i] = high_q[i] ? (m100 > thr_h97)
				: (mag_q[i] > thr_high);
			// low: set below, clear above low/0.97
			// widened to 32 bits so the squared scale cannot wrap
			low_d[i] = low_q[i] ? ({8'h00, m100} * `HYST_NUM
				< {16'h0000, thr_low} * `HYST_DEN * `HYST_DEN)
				: (mag_q[i] < thr_low);
		end
	end

	wire all_low  = &low_q;
	wire all_high = &high_q;
	wire any_over = |over_q;
	wire mid_band = ~all_low & ~all_high & ~any_over;

	// ----------------------------------------
	// sequence state
	// ----------------------------------------
	reg [1:0]        state_q;
	reg [TIME_W-1:0] low_tmr_q, max_tmr_q, min_tmr_q;
	reg              high_seen_q;
	wire [TIME_W-1:0] low_ms = low_tmr_q * `TICK_MS;
	wire [TIME_W-1:0] max_ms = max_tmr_q * `TICK_MS;
	wire [TIME_W-1:0] min_ms = min_tmr_q * `TICK_MS;
	wire start_done = (low_ms + `TICK_MS > t_start_ms) ||
		(t_start_ms == {TIME_W{1'b0}});
	wire pickup = all_low & start_done;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mag_q[0]      <= {MAG_W{1'b0}};
			mag_q[1]      <= {MAG_W{1'b0}};
			mag_q[2]      <= {MAG_W{1'b0}};
			over_q        <= 3'h0;
			high_q        <= 3'h0;
			low_q         <= 3'h0;
			blk_sampled_q <= 1'b0;
			state_q       <= ST_IDLE;
			low_tmr_q     <= {TIME_W{1'b0}};
			max_tmr_q     <= {TIME_W{1'b0}};
			min_tmr_q     <= {TIME_W{1'b0}};
			high_seen_q   <= 1'b0;
			tick_out      <= 1'b0;
		end
		else if (clk_en)
		begin
			tick_out <= tick;
			if (tick)
			begin
				mag_q[0] <= phase_a_magnitude;
				mag_q[1] <= phase_b_magnitude;
				mag_q[2] <= phase_c_magnitude;
				over_q   <= over_d;
				high_q   <= high_d;
				low_q    <= low_d;
				blk_sampled_q <= blk_stable_q;
				low_tmr_q <= all_low ? low_tmr_q + 1'b1
					: {TIME_W{1'b0}};
				case (state_q)
				ST_IDLE:
				begin
					max_tmr_q   <= {TIME_W{1'b0}};
					min_tmr_q   <= {TIME_W{1'b0}};
					high_seen_q <= 1'b0;
					if (pickup && !node_off)
						state_q <= blk_sampled_q ? ST_BLK : ST_ACT;
				end
				ST_ACT:
				begin
					if (all_high)
						high_seen_q <= 1'b1;
					max_tmr_q <= all_high ? max_tmr_q + 1'b1
						: max_tmr_q;
					min_tmr_q <= all_low ? {TIME_W{1'b0}}
						: min_tmr_q + 1'b1;
					if (blk_sampled_q || any_over || node_off)
						state_q <= ST_IDLE;
					else if (all_high &&
						max_ms + `TICK_MS >= t_max_ms)
						state_q <= ST_IDLE;
					else if (mid_band &&
						min_ms + `TICK_MS >= t_min_ms)
						state_q <= ST_IDLE;
				end
				ST_BLK:
				begin
					if (!blk_sampled_q || !all_low)
						state_q <= ST_IDLE;
				end
				default:
					state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// outputs and status
	// ----------------------------------------
	// late block is the feeder's hazard
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			surge_active_out       <= 1'b0;
			surge_blocked_out      <= 1'b0;
			surge_condition_status <= `COND_NORMAL;
			node_mode_status       <= `MODE_HIDDEN;
		end
		else if (clk_en)
		begin
			surge_active_out  <= (state_q == ST_ACT);
			surge_blocked_out <= (state_q == ST_BLK);
			if (state_q == ST_BLK)
				surge_condition_status <= `COND_BLOCKED;
			else if (any_over)
				surge_condition_status <= `COND_OVER;
			else if (state_q == ST_ACT)
				surge_condition_status <= `COND_ACTIVE;
			else if (all_low)
				surge_condition_status <= `COND_LOW;
			else
				surge_condition_status <= `COND_NORMAL;
			if (!node_mode_enable)
				node_mode_status <= `MODE_HIDDEN;
			else if (node_off)
				node_mode_status <= `MODE_OFF;
			else if (node_test)
				node_mode_status <= blk_stable_q ? `MODE_TEST_BLK
					: `MODE_TEST;
			else
				node_mode_status <= blk_stable_q ? `MODE_BLOCKED
					: `MODE_ON;
		end
	end

endmodule

// ==== verif/surge_props.sv ====
// port assertions for the cold-load surge detector
`include "surge_defines.vh"
module surge_props
#(
	parameter TICK_CYCLES = 10
)
(
	input wire       clock,
	input wire       arst_n,
	input wire       node_off,
	input wire       node_mode_enable,
	input wire       surge_active_out,
	input wire       surge_blocked_out,
	input wire       tick_out,
	input wire [2:0] surge_condition_status,
	input wire [2:0] node_mode_status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// cycles since last tick, -1 until the first one
	integer cnt_q;
	always @(posedge clock or negedge arst_n)
		if (!arst_n)
			cnt_q <= -1;
		else if (tick_out)
			cnt_q <= 0;
		else if (cnt_q >= 0)
			cnt_q <= cnt_q + 1;
	property p_tick; tick_out && cnt_q >= 0 |-> cnt_q == TICK_CYCLES - 1;
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing");
	property p_near; $rose(surge_active_out) |->
		cnt_q <= 2 || cnt_q >= TICK_CYCLES - 3; endproperty
	a_near: assert property (p_near) else $error("rise off tick");
	property p_excl; !(surge_active_out && surge_blocked_out); endproperty
	a_excl: assert property (p_excl) else $error("both outputs");
	property p_sblk; surge_blocked_out |->
		surge_condition_status == `COND_BLOCKED; endproperty
	a_sblk: assert property (p_sblk) else $error("blocked status");
	property p_sact; surge_active_out |->
		surge_condition_status inside {`COND_ACTIVE, `COND_OVER}; endproperty
	a_sact: assert property (p_sact) else $error("active status");
	property p_range; surge_condition_status <= `COND_BLOCKED; endproperty
	a_range: assert property (p_range) else $error("status code");
	property p_hide; !node_mode_enable [*3] |->
		node_mode_status == `MODE_HIDDEN; endproperty
	a_hide: assert property (p_hide) else $error("mode shown");
	property p_off; (node_mode_enable && node_off) [*3] |->
		node_mode_status == `MODE_OFF; endproperty
	a_off: assert property (p_off) else $error("mode not off");
endmodule
bind cold_load_detector surge_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
	.clock, .arst_n, .node_off, .node_mode_enable, .surge_active_out,
	.surge_blocked_out, .tick_out, .surge_condition_status,
	.node_mode_status);

// ==== verif/meas_chain.sv ====
// phase measurement chain and blocking matrix stand-in
module meas_chain
(
	input  wire         clock,
	input  wire         tick_out,
	input  wire  [47:0] tgt,
	input  wire         blk_req,
	output logic [47:0] mag,
	output logic        block_in
);
	initial mag = 48'h0;
	initial block_in = 1'b0;
	always @(posedge clock)
		if (tick_out)
			mag <= tgt;
	// passed one clock later, well ahead of delays
	always @(posedge clock)
		block_in <= blk_req;
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the cold-load surge detector
`include "surge_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam TC = 10;
	localparam logic [14:0] MIN = {3'b110, 3'b100, 3'b010, 3'b001, 3'b000};
	localparam logic [14:0] MEX = {3'h3, 3'h1, 3'h2, 3'h4, 3'h0};
	logic        clock, arst_n, blk_req, node_test, node_off;
	logic        node_mode_enable, act, blk, block_in, tick;
	logic [47:0] tgt, mag;
	logic [15:0] thr_low, thr_high, thr_over;
	logic [23:0] t_start, t_max, t_min;
	logic [2:0]  cond, mode;
	integer      i;
	integer      miscompares = 0;
	integer      num_checks = 0;
	meas_chain i_meas (.clock, .tick_out(tick), .tgt, .blk_req, .mag,
		.block_in);
	cold_load_detector #(.TICK_CYCLES(TC)) i_dut (.clock, .arst_n,
		.clk_en(1'b1), .phase_a_magnitude(mag[47:32]),
		.phase_b_magnitude(mag[31:16]), .phase_c_magnitude(mag[15:0]),
		.thr_low, .thr_high, .thr_over, .t_start_ms(t_start),
		.t_max_ms(t_max), .t_min_ms(t_min), .block_in, .node_test,
		.node_off, .node_mode_enable, .surge_active_out(act),
		.surge_blocked_out(blk), .tick_out(tick),
		.surge_condition_status(cond), .node_mode_status(mode));
	task chk(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task put(input logic [47:0] v);
		@(posedge clock);
		tgt <= v;
	endtask
	task wait_act(input logic v, input integer lim);
		integer n;
		// look off the edge so registered outputs have settled
		#1;
		for (n = 0; n < lim && act !== v; n++)
		begin
			@(posedge clock);
			#1;
		end
		chk({2'h0, act}, {2'h0, v});
	endtask
	task end_of_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	// hang guard, far beyond the planned run
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_of_test;
	end
	initial
	begin
		{arst_n, blk_req, node_test, node_off, node_mode_enable} = 5'h00;
		{thr_low, thr_high, thr_over} = {`THR_LOW_RST, `THR_HIGH_RST,
			`THR_OVER_RST};
		{t_start, t_max, t_min} = {24'h14, 24'h32, 24'h14};
		tgt = {16'h000a, 16'h000a, 16'h0064};
		repeat (12) @(posedge clock);
		chk(cond, `COND_NORMAL);
		chk(mode, `MODE_HIDDEN);
		chk({act, blk, 1'b0}, 3'h0);
		arst_n <= 1;
		repeat (12 * TC) @(posedge clock);
		wait_act(1'b0, 1);
		put({3{16'h000a}});
		repeat (2 * TC) @(posedge clock);
		wait_act(1'b0, 1);
		wait_act(1'b1, 10 * TC);
		chk(cond, `COND_ACTIVE);
		put({3{16'h0096}});
		repeat (6 * TC) @(posedge clock);
		wait_act(1'b1, 1);
		wait_act(1'b0, 10 * TC);
		put({3{16'h000a}});
		wait_act(1'b1, 12 * TC);
		put({16'h00d2, 16'h000a, 16'h000a});
		wait_act(1'b0, 5 * TC);
		chk(cond, `COND_OVER);
		put({16'h00c3, 16'h000a, 16'h000a});
		repeat (4 * TC) @(posedge clock);
		chk(cond, `COND_OVER);
		put({3{16'h000a}});
		wait_act(1'b1, 12 * TC);
		put({3{16'h0064}});
		repeat (2 * TC) @(posedge clock);
		wait_act(1'b1, 1);
		wait_act(1'b0, 8 * TC);
		put({3{16'h000a}});
		t_start <= 24'h0;
		wait_act(1'b1, 4 * TC);
		@(posedge clock);
		blk_req <= 1'b1;
		wait_act(1'b0, 4 * TC);
		repeat (4 * TC) @(posedge clock);
		#1;
		chk(cond, `COND_BLOCKED);
		chk({2'h0, blk}, 3'h1);
		@(posedge clock);
		blk_req <= 1'b0;
		wait_act(1'b1, 6 * TC);
		for (i = 0; i < 5; i++)
		begin
			@(posedge clock);
			{node_mode_enable, blk_req, node_test, node_off} <= {1'b1,
				MIN[i*3 +: 3]};
			repeat (8) @(posedge clock);
			#1;
			chk(mode, MEX[i*3 +: 3]);
		end
		end_of_test;
	end
endmodule
